// file: design/scl_cnt_top.sv
// SCL period count registers and the SCL generator that uses them.
// Registers sit on REF_CLK; the generator runs on CONTROLLER_CLOCK.
`timescale 1ns/10ps
module scl_cnt_top
  import scl_cnt_pkg::*;
#(
  parameter scl_speed_t SPEED_MAX = SPD_HIGH
) (
  // Register side clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  // Register port
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Controller clock and sequencer controls
  input  wire logic              CONTROLLER_CLOCK,
  input  wire logic              CLK_RUN,
  input  wire logic              HS_PREAMBLE,
  input  wire logic [CNT_W-1:0]  HS_HCNT,
  input  wire logic [CNT_W-1:0]  HS_LCNT,
  // Bus pins
  input  wire logic              SCL_IN,
  output logic                   SCL_OUT,
  output logic                   SCL_OE_N,
  input  wire logic              SDA_IN,
  // Status
  output logic                   BUS_IDLE
);

  localparam bit FS_PRESENT = (SPEED_MAX != SPD_STD);

  // ---------------- Register side ----------------
  scl_cnt_if #(.W(CNT_W)) ss_h_if ();
  scl_cnt_if #(.W(CNT_W)) ss_l_if ();
  scl_cnt_if #(.W(CNT_W)) fs_h_if ();
  scl_cnt_if #(.W(CNT_W)) fs_l_if ();

  logic       enable_reg;
  scl_speed_t speed_reg;
  logic       wr_acc;
  logic       mapped;
  logic [1:0] wr_speed;
  logic [1:0] act_sync_reg;
  logic [1:0] idle_sync_reg;
  logic [31:0] rdata_reg;
  // Written on the controller clock, read here only through the synchronisers
  logic       act_reg;
  logic       idle_reg;

  assign wr_acc = PSEL && PENABLE && PWRITE;

  always_comb begin
    mapped = 1'b1;
    case (PADDR)
      OFS_CTRL, OFS_SS_HCNT, OFS_SS_LCNT, OFS_FS_HCNT,
      OFS_FS_LCNT, OFS_ENABLE, OFS_STATUS: mapped = 1'b1;
      default:                             mapped = 1'b0;
    endcase
  end

  assign ss_h_if.wr_stb   = wr_acc && (PADDR == OFS_SS_HCNT);
  assign ss_l_if.wr_stb   = wr_acc && (PADDR == OFS_SS_LCNT);
  assign fs_h_if.wr_stb   = wr_acc && (PADDR == OFS_FS_HCNT);
  assign fs_l_if.wr_stb   = wr_acc && (PADDR == OFS_FS_LCNT);
  assign ss_h_if.wr_data  = PWDATA[CNT_W-1:0];
  assign ss_l_if.wr_data  = PWDATA[CNT_W-1:0];
  assign fs_h_if.wr_data  = PWDATA[CNT_W-1:0];
  assign fs_l_if.wr_data  = PWDATA[CNT_W-1:0];
  assign ss_h_if.wr_allow = !enable_reg;
  assign ss_l_if.wr_allow = !enable_reg;
  assign fs_h_if.wr_allow = !enable_reg;
  assign fs_l_if.wr_allow = !enable_reg;

  scl_cnt_reg #(.RESET_VAL(RST_SS_HCNT), .MIN_VAL(MIN_SS_HCNT), .PRESENT(1'b1)) u_ss_h (
    .clk  (REF_CLK),
    .rst  (RST),
    .port (ss_h_if)
  );
  scl_cnt_reg #(.RESET_VAL(RST_SS_LCNT), .MIN_VAL(MIN_SS_LCNT), .PRESENT(1'b1)) u_ss_l (
    .clk  (REF_CLK),
    .rst  (RST),
    .port (ss_l_if)
  );
  scl_cnt_reg #(.RESET_VAL(RST_FS_HCNT), .MIN_VAL(MIN_FS_HCNT), .PRESENT(FS_PRESENT)) u_fs_h (
    .clk  (REF_CLK),
    .rst  (RST),
    .port (fs_h_if)
  );
  scl_cnt_reg #(.RESET_VAL(RST_FS_LCNT), .MIN_VAL(MIN_FS_LCNT), .PRESENT(FS_PRESENT)) u_fs_l (
    .clk  (REF_CLK),
    .rst  (RST),
    .port (fs_l_if)
  );

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      enable_reg <= 1'b0;
    end else if (wr_acc && PADDR == OFS_ENABLE) begin
      enable_reg <= PWDATA[ENABLE_BIT];
    end
  end

  // A speed beyond the build limit falls back to that limit
  assign wr_speed = PWDATA[CTRL_SPD_LSB +: 2];

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      speed_reg <= RST_SPEED;
    end else if (wr_acc && PADDR == OFS_CTRL && !enable_reg) begin
      if (wr_speed == 2'h0) begin
        speed_reg <= SPD_STD;
      end else if (wr_speed > SPEED_MAX) begin
        speed_reg <= SPEED_MAX;
      end else begin
        speed_reg <= scl_speed_t'(wr_speed);
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      act_sync_reg  <= 2'b00;
      idle_sync_reg <= 2'b00;
    end else begin
      act_sync_reg  <= {act_sync_reg[0], act_reg};
      idle_sync_reg <= {idle_sync_reg[0], idle_reg};
    end
  end

  // Read data captured in the setup phase so it is a flop in the access phase
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      case (PADDR)
        OFS_CTRL:    rdata_reg <= {29'h0000_0000, speed_reg, 1'b0};
        OFS_SS_HCNT: rdata_reg <= {16'h0000, ss_h_if.value};
        OFS_SS_LCNT: rdata_reg <= {16'h0000, ss_l_if.value};
        OFS_FS_HCNT: rdata_reg <= {16'h0000, fs_h_if.value};
        OFS_FS_LCNT: rdata_reg <= {16'h0000, fs_l_if.value};
        OFS_ENABLE:  rdata_reg <= {31'h0000_0000, enable_reg};
        OFS_STATUS:  rdata_reg <= {30'h0000_0000, idle_sync_reg[1], act_sync_reg[1]};
        default:     rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign PRDATA  = rdata_reg;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // ---------------- Controller clock side ----------------
  logic [1:0]       rst_sync_reg;
  logic             rst_l;
  logic [1:0]       en_sync_reg;
  logic             en_d_reg;
  logic             en_l;
  logic [2:0]       scl_pin_reg;
  logic [2:0]       sda_pin_reg;
  logic             scl_lvl_reg;
  logic             sda_lvl_reg;
  logic [CNT_W-1:0] snap_ss_h;
  logic [CNT_W-1:0] snap_ss_l;
  logic [CNT_W-1:0] snap_fs_h;
  logic [CNT_W-1:0] snap_fs_l;
  scl_speed_t       snap_speed;
  logic [CNT_W-1:0] hi_cnt;
  logic [CNT_W-1:0] lo_cnt;
  scl_state_t       state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             oe_n_reg;
  logic [CNT_W-1:0] idle_cnt_reg;
  logic [CNT_W-1:0] idle_limit;
  logic             go;

  always_ff @(posedge CONTROLLER_CLOCK) begin
    rst_sync_reg <= {rst_sync_reg[0], RST};
  end
  assign rst_l = rst_sync_reg[1];

  always_ff @(posedge CONTROLLER_CLOCK) begin
    if (rst_l) begin
      en_sync_reg <= 2'b00;
      en_d_reg    <= 1'b0;
    end else begin
      en_sync_reg <= {en_sync_reg[0], enable_reg};
      en_d_reg    <= en_sync_reg[1];
    end
  end
  assign en_l = en_sync_reg[1];

  // Counts are frozen while enabled, so a snapshot at the enable edge is safe
  always_ff @(posedge CONTROLLER_CLOCK) begin
    if (rst_l) begin
      snap_ss_h  <= RST_SS_HCNT;
      snap_ss_l  <= RST_SS_LCNT;
      snap_fs_h  <= FS_PRESENT ? RST_FS_HCNT : 16'h0000;
      snap_fs_l  <= FS_PRESENT ? RST_FS_LCNT : 16'h0000;
      snap_speed <= RST_SPEED;
    end else if (en_l && !en_d_reg) begin
      snap_ss_h  <= ss_h_if.value;
      snap_ss_l  <= ss_l_if.value;
      snap_fs_h  <= fs_h_if.value;
      snap_fs_l  <= fs_l_if.value;
      snap_speed <= speed_reg;
    end
  end

  // Pin levels change only once the second and third stages agree
  always_ff @(posedge CONTROLLER_CLOCK) begin
    if (rst_l) begin
      scl_pin_reg <= 3'b111;
      sda_pin_reg <= 3'b111;
      scl_lvl_reg <= 1'b1;
      sda_lvl_reg <= 1'b1;
    end else begin
      scl_pin_reg <= {scl_pin_reg[1:0], SCL_IN};
      sda_pin_reg <= {sda_pin_reg[1:0], SDA_IN};
      if (scl_pin_reg[1] == scl_pin_reg[2]) begin
        scl_lvl_reg <= scl_pin_reg[2];
      end
      if (sda_pin_reg[1] == sda_pin_reg[2]) begin
        sda_lvl_reg <= sda_pin_reg[2];
      end
    end
  end

  always_comb begin
    hi_cnt = snap_ss_h;
    lo_cnt = snap_ss_l;
    case (snap_speed)
      SPD_FAST: begin
        hi_cnt = snap_fs_h;
        lo_cnt = snap_fs_l;
      end
      SPD_HIGH: begin
        hi_cnt = HS_PREAMBLE ? snap_fs_h : HS_HCNT;
        lo_cnt = HS_PREAMBLE ? snap_fs_l : HS_LCNT;
      end
      default: begin
        hi_cnt = snap_ss_h;
        lo_cnt = snap_ss_l;
      end
    endcase
  end

  // Start one edge after the snapshot, so the first low phase uses fresh counts
  assign go = en_l && en_d_reg && CLK_RUN;

  // High phase waits for the line to read high, so a stretching target holds it
  always_ff @(posedge CONTROLLER_CLOCK) begin
    if (rst_l) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 16'h0000;
      oe_n_reg  <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            state_reg <= ST_LOW;
            cnt_reg   <= lo_cnt;
            oe_n_reg  <= 1'b0;
          end
        end
        ST_LOW: begin
          if (!go) begin
            state_reg <= ST_IDLE;
            oe_n_reg  <= 1'b1;
          end else if (cnt_reg <= 16'h0001) begin
            state_reg <= ST_HIGH;
            cnt_reg   <= hi_cnt;
            oe_n_reg  <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        ST_HIGH: begin
          if (!go) begin
            state_reg <= ST_IDLE;
          end else if (scl_lvl_reg) begin
            if (cnt_reg <= 16'h0001) begin
              state_reg <= ST_LOW;
              cnt_reg   <= lo_cnt;
              oe_n_reg  <= 1'b0;
            end else begin
              cnt_reg <= cnt_reg - 16'h0001;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          oe_n_reg  <= 1'b1;
        end
      endcase
    end
  end

  // Limit wraps above 65525; software must keep the high count below that
  assign idle_limit = CNT_W'(snap_ss_h + IDLE_MARGIN);

  always_ff @(posedge CONTROLLER_CLOCK) begin
    if (rst_l) begin
      idle_cnt_reg <= 16'h0000;
      idle_reg     <= 1'b0;
      act_reg      <= 1'b0;
    end else begin
      act_reg <= (state_reg != ST_IDLE);
      if (state_reg != ST_IDLE || !scl_lvl_reg || !sda_lvl_reg) begin
        idle_cnt_reg <= 16'h0000;
        idle_reg     <= 1'b0;
      end else if (idle_cnt_reg == idle_limit) begin
        idle_reg     <= 1'b1;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 16'h0001;
      end
    end
  end

  assign SCL_OUT  = 1'b0;
  assign SCL_OE_N = oe_n_reg;
  assign BUS_IDLE = idle_reg;

endmodule : scl_cnt_top

// file: pkg/scl_cnt_pkg.sv
// Constants and types for the SCL period count register block.
// Assumes a 32-bit register port with byte addresses and one controller clock.
package scl_cnt_pkg;

  localparam int          CNT_W        = 16;
  localparam int          ADDR_W       = 8;

  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_SS_HCNT  = 8'h14;
  localparam logic [7:0]  OFS_SS_LCNT  = 8'h18;
  localparam logic [7:0]  OFS_FS_HCNT  = 8'h1c;
  localparam logic [7:0]  OFS_FS_LCNT  = 8'h20;
  localparam logic [7:0]  OFS_ENABLE   = 8'h6c;
  localparam logic [7:0]  OFS_STATUS   = 8'h70;

  localparam logic [15:0] RST_SS_HCNT  = 16'h0028;
  localparam logic [15:0] RST_SS_LCNT  = 16'h002f;
  localparam logic [15:0] RST_FS_HCNT  = 16'h0006;
  localparam logic [15:0] RST_FS_LCNT  = 16'h000d;

  localparam logic [15:0] MIN_SS_HCNT  = 16'h0006;
  localparam logic [15:0] MIN_SS_LCNT  = 16'h0008;
  localparam logic [15:0] MIN_FS_HCNT  = 16'h0006;
  localparam logic [15:0] MIN_FS_LCNT  = 16'h0008;

  localparam logic [15:0] IDLE_MARGIN  = 16'h000a;

  localparam int          CTRL_SPD_LSB = 1;
  localparam int          ENABLE_BIT   = 0;
  localparam int          STAT_ACT_BIT = 0;
  localparam int          STAT_IDL_BIT = 1;

  typedef enum logic [1:0] {
    SPD_STD  = 2'h1,
    SPD_FAST = 2'h2,
    SPD_HIGH = 2'h3
  } scl_speed_t;

  localparam scl_speed_t  RST_SPEED    = SPD_STD;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b11
  } scl_state_t;

endpackage : scl_cnt_pkg

// file: pkg/scl_cnt_if.sv
// Write port and stored value of one count register.
// Driven by the register decode in the top module on the bus clock.
`timescale 1ns/10ps
interface scl_cnt_if #(
  parameter int W = 16
);
  logic         wr_stb;
  logic [W-1:0] wr_data;
  logic         wr_allow;
  logic [W-1:0] value;

  modport regs (input wr_stb, input wr_data, input wr_allow, output value);
  modport ctrl (output wr_stb, output wr_data, output wr_allow, input value);
endinterface : scl_cnt_if

// file: design/scl_cnt_reg.sv
// One SCL period count register with floor clamp and build-time presence.
// Assumes synchronous active-high reset on the bus clock.
`timescale 1ns/10ps
module scl_cnt_reg
  import scl_cnt_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = 16'h0008,
  parameter logic [15:0] MIN_VAL   = 16'h0008,
  parameter bit          PRESENT   = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access
  scl_cnt_if.regs  port
);

  logic [CNT_W-1:0] value_reg;

  // An absent register holds zero and ignores every write
  always_ff @(posedge clk) begin
    if (rst) begin
      value_reg <= PRESENT ? RESET_VAL : 16'h0000;
    end else if (PRESENT && port.wr_stb && port.wr_allow) begin
      value_reg <= (port.wr_data < MIN_VAL) ? MIN_VAL : port.wr_data;
    end
  end

  assign port.value = value_reg;

endmodule : scl_cnt_reg

// file: tb/scl_cnt_properties.sv
// Port-level checks for the SCL count register block and its generator.
// Bound to every scl_cnt_top instance; sees only its top-level pins.
`timescale 1ns/10ps
module scl_cnt_properties
  import scl_cnt_pkg::*;
(
  // Clocks and reset
  input wire logic              REF_CLK,
  input wire logic              RST,
  input wire logic              CONTROLLER_CLOCK,
  // Register port
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  // Link side
  input wire logic              CLK_RUN,
  input wire logic              SCL_OUT,
  input wire logic              SCL_OE_N,
  input wire logic              BUS_IDLE
);
  logic       mapped;
  logic [7:0] hi_run_reg;

  assign mapped = PADDR inside {OFS_CTRL, OFS_SS_HCNT, OFS_SS_LCNT, OFS_FS_HCNT,
                                OFS_FS_LCNT, OFS_ENABLE, OFS_STATUS};

  // Saturates so a long idle stretch cannot wrap back under the floor
  always_ff @(posedge CONTROLLER_CLOCK) begin
    if (RST || !SCL_OE_N) hi_run_reg <= 8'h00;
    else if (hi_run_reg != 8'hff) hi_run_reg <= hi_run_reg + 8'h01;
  end

  a_ready_high: assert property (@(posedge REF_CLK) disable iff (RST) PREADY)
    else $error("ready dropped");
  a_err_unmapped: assert property (@(posedge REF_CLK) disable iff (RST)
    PSEL && PENABLE |-> PSLVERR == !mapped) else $error("error flag wrong for address");
  a_err_quiet: assert property (@(posedge REF_CLK) disable iff (RST)
    !(PSEL && PENABLE) |-> !PSLVERR) else $error("error flag outside access");
  a_upper_zero: assert property (@(posedge REF_CLK) disable iff (RST)
    PRDATA[31:16] == 16'h0000) else $error("upper read bits set");
  a_rdata_holds: assert property (@(posedge REF_CLK) disable iff (RST)
    !(PSEL && !PENABLE) |=> $stable(PRDATA)) else $error("read data moved");
  a_low_floor: assert property (@(posedge CONTROLLER_CLOCK) disable iff (RST)
    $fell(SCL_OE_N) |-> (!SCL_OE_N || !CLK_RUN) [*8]) else $error("low phase short");
  a_high_floor: assert property (@(posedge CONTROLLER_CLOCK) disable iff (RST)
    $rose(SCL_OE_N) && CLK_RUN |-> SCL_OE_N [*6]) else $error("high phase short");
  a_idle_drops: assert property (@(posedge CONTROLLER_CLOCK) disable iff (RST)
    !SCL_OE_N [*6] |-> !BUS_IDLE) else $error("idle while clock low");
  a_idle_wait: assert property (@(posedge CONTROLLER_CLOCK) disable iff (RST)
    $rose(BUS_IDLE) |-> hi_run_reg >= 8'h10) else $error("idle flagged early");
  a_pin_low: assert property (@(posedge CONTROLLER_CLOCK) disable iff (RST)
    SCL_OUT == 1'b0) else $error("pin output not low");

  c_bad_addr: cover property (@(posedge REF_CLK) PSEL && PENABLE && PSLVERR);
  c_clock_low: cover property (@(posedge CONTROLLER_CLOCK) $fell(SCL_OE_N));
  c_idle: cover property (@(posedge CONTROLLER_CLOCK) $rose(BUS_IDLE));
endmodule : scl_cnt_properties

bind scl_cnt_top scl_cnt_properties u_props (
  .REF_CLK(REF_CLK), .RST(RST), .CONTROLLER_CLOCK(CONTROLLER_CLOCK), .PSEL(PSEL),
  .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .CLK_RUN(CLK_RUN), .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N),
  .BUS_IDLE(BUS_IDLE)
);

// file: tb/scl_cnt_bus_model.sv
// Far side of the SCL and SDA pins: pull-ups and a target that may stretch SCL.
// Assumes the controller pulls SCL low only through its active-low enable.
`timescale 1ns/10ps
module scl_cnt_bus_model (
  // Pin controls
  input  wire logic ctl_oe_n,
  input  wire logic ctl_out,
  input  wire logic stretch,
  // Wired lines
  output logic      scl,
  output logic      sda
);
  // Open drain: any party pulling wins, otherwise the pull-up
  assign scl = !((!ctl_oe_n && !ctl_out) || stretch);
  // No target answers here, so data stays released high
  assign sda = 1'b1;
endmodule : scl_cnt_bus_model

// file: tb/scl_cnt_top_bench.sv
// Self-checking bench for the SCL count registers and the generator behind them.
// Drives the register port on the falling REF_CLK edge; link clock runs free.
`timescale 1ns/10ps
module scl_cnt_top_bench
  import scl_cnt_pkg::*;
;
  logic              clk, cclk, rst, psel, psel_b, pen, pwr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, prdata_b, rd;
  logic              pready, pslverr, pslverr_b, er;
  logic              run, hs, stretch, oe_n, scl_o, scl, sda, idle;
  logic [15:0]       hs_h, hs_l;
  int                failures, samples_checked, lo, hi, k, h;
  int                m_cnt [4];
  int                mins [4] = '{MIN_SS_HCNT, MIN_SS_LCNT, MIN_FS_HCNT, MIN_FS_LCNT};
  bit                m_en;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    cclk = 1'b0;
    #7;
    forever #15 cclk = ~cclk;
  end

  scl_cnt_top uut (
    .REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CONTROLLER_CLOCK(cclk), .CLK_RUN(run), .HS_PREAMBLE(hs), .HS_HCNT(hs_h),
    .HS_LCNT(hs_l), .SCL_IN(scl), .SCL_OUT(scl_o), .SCL_OE_N(oe_n), .SDA_IN(sda),
    .BUS_IDLE(idle));
  scl_cnt_top #(.SPEED_MAX(SPD_STD)) uut_std (
    .REF_CLK(clk), .RST(rst), .PSEL(psel_b), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata_b), .PREADY(), .PSLVERR(pslverr_b),
    .CONTROLLER_CLOCK(cclk), .CLK_RUN(run), .HS_PREAMBLE(hs), .HS_HCNT(hs_h),
    .HS_LCNT(hs_l), .SCL_IN(scl), .SCL_OUT(), .SCL_OE_N(), .SDA_IN(sda), .BUS_IDLE());
  scl_cnt_bus_model bus (
    .ctl_oe_n(oe_n), .ctl_out(scl_o), .stretch(stretch), .scl(scl), .sda(sda));

  function automatic logic [7:0] ofs(input int i);
    return 8'(OFS_SS_HCNT + 4 * i);
  endfunction : ofs

  task automatic give_verdict();
    $display("checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic guard(input bit hit);
    if (hit) begin
      failures++;
      give_verdict();
    end
  endtask : guard

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input bit b, input logic [7:0] a, input logic [31:0] d, input bit w);
    @(negedge clk);
    psel = !b;
    psel_b = b;
    pwr = w;
    paddr = a;
    pwdata = d;
    @(negedge clk);
    pen = 1'b1;
    @(posedge clk);
    rd = b ? prdata_b : prdata;
    er = b ? pslverr_b : pslverr;
    @(negedge clk);
    psel = 1'b0;
    psel_b = 1'b0;
    pen = 1'b0;
  endtask : apb

  // Reference model: clamp to floor, drop count writes while enabled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, d, 1'b1);
    if (a == OFS_ENABLE) m_en = d[0];
    for (int i = 0; i < 4; i++)
      if (a == ofs(i) && !m_en) m_cnt[i] = (d[15:0] < mins[i]) ? mins[i] : d[15:0];
  endtask : wr

  task automatic rdchk(input bit b, input logic [7:0] a, input logic [31:0] exp);
    apb(b, a, 32'h0000_0000, 1'b0);
    check(rd, exp);
  endtask : rdchk

  // Phase lengths in link-clock edges, starting from a fresh low phase
  task automatic measure();
    lo = 0;
    hi = 0;
    for (k = 0; k < 2000 && oe_n !== 1'b1; k++) @(negedge cclk);
    for (k = 0; k < 2000 && oe_n !== 1'b0; k++) @(negedge cclk);
    while (oe_n === 1'b0 && lo < 2000) begin
      @(negedge cclk);
      lo++;
    end
    while (oe_n === 1'b1 && hi < 2000) begin
      @(negedge cclk);
      hi++;
    end
    guard(k >= 2000 || lo >= 2000 || hi >= 2000);
  endtask : measure

  initial begin
    {psel, psel_b, pen, pwr, run, hs, stretch, m_en} = '0;
    paddr = '0;
    pwdata = '0;
    hs_h = 16'h0007;
    hs_l = 16'h0009;
    failures = 0;
    samples_checked = 0;
    m_cnt = '{RST_SS_HCNT, RST_SS_LCNT, RST_FS_HCNT, RST_FS_LCNT};
    rst = 1'b1;
    k = $urandom(32'h25af_7e98);
    repeat (16) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) rdchk(1'b0, ofs(i), m_cnt[i]);
    // Below floor, at floor, then random with junk in the upper half
    for (int i = 0; i < 12; i++) begin
      h = (i < 4) ? mins[i] - 1 : (i < 8) ? mins[i % 4] : $urandom_range(40, 0);
      wr(ofs(i % 4), ($urandom & 32'hffff_0000) | h);
      rdchk(1'b0, ofs(i % 4), m_cnt[i % 4]);
    end
    for (int s = 1; s < 4; s++) begin
      wr(OFS_ENABLE, 32'h0000_0000);
      for (int i = 0; i < 4; i++) wr(ofs(i), $urandom_range(20, 0));
      wr(OFS_CTRL, 32'(s << CTRL_SPD_LSB));
      wr(OFS_ENABLE, 32'h0000_0001);
      wr(ofs(s), $urandom_range(40, 0));
      rdchk(1'b0, ofs(s), m_cnt[s]);
      h = (s == 1) ? 0 : 2;
      hs = (s == 3);
      run = 1'b1;
      measure();
      check(32'(lo), 32'(m_cnt[h + 1]));
      check(32'(hi >= m_cnt[h] && hi <= m_cnt[h] + 8), 32'h0000_0001);
      // Outside the preamble the high-speed counts from the ports take over
      if (s == 3) begin
        hs = 1'b0;
        measure();
        check(32'(lo), 32'(hs_l));
        check(32'(hi >= hs_h && hi <= hs_h + 8), 32'h0000_0001);
      end
      @(negedge cclk);
      run = 1'b0;
      for (k = 0; k < 500 && idle !== 1'b1; k++) @(negedge cclk);
      guard(k >= 500);
      check(32'(k >= m_cnt[0] + 11 && k <= m_cnt[0] + 22), 32'h0000_0001);
      // Give the status synchronisers two bus-clock edges before reading
      repeat (2) @(negedge clk);
      rdchk(1'b0, OFS_STATUS, 32'(1 << STAT_IDL_BIT));
    end
    apb(1'b0, 8'h44, 32'h0000_0000, 1'b0);
    check({31'h0, er}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    // Standard-only build: fast counts absent, standard count still clamps
    apb(1'b1, OFS_FS_HCNT, 32'h0000_0010, 1'b1);
    apb(1'b1, OFS_FS_LCNT, 32'h0000_0020, 1'b1);
    apb(1'b1, OFS_SS_LCNT, 32'h0000_0003, 1'b1);
    rdchk(1'b1, OFS_FS_HCNT, 32'h0000_0000);
    rdchk(1'b1, OFS_FS_LCNT, 32'h0000_0000);
    rdchk(1'b1, OFS_SS_LCNT, 32'(MIN_SS_LCNT));
    give_verdict();
  end
endmodule : scl_cnt_top_bench
